// ==== test/bar_arbiter_asserts.sv ====
// checker for the bus arbitration and release block
// assumes it is bound to the arbiter and sees its ports only
`timescale 1ns/1ns
module bar_arbiter_asserts (
	// clock and reset
	input wire clock_i,
	input wire reset_i,
	// release pins
	input wire ext_bus_request_n_i,
	input wire bus_ack_n_o,
	input wire bus_reclaim_request_n_o,
	input wire ctrl_high_o,
	input wire ext_out_en_o,
	input wire dma_ack_out_n_force_o,
	input wire precharge_all_cmd_o,
	// arbiter outputs
	input wire ext_go_o,
	input wire refresh_go_o,
	input wire dma_gnt_o,
	input wire tc_gnt_o,
	input wire cpu_gnt_o,
	// write buffers
	input wire ext_wr_run_i,
	input wire per_wr_run_i,
	input wire int_go_o,
	input wire mem_go_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// a go signal held low for the two cycles a buffered write runs alone
	sequence s_alone(x);
		!x ##1 !x;
	endsequence
	property p_float; !bus_ack_n_o |-> !ext_out_en_o && dma_ack_out_n_force_o; endproperty
	a_float: assert property (p_float) else $error("outputs driven while released");
	property p_precharge_all_cmd; precharge_all_cmd_o |-> bus_ack_n_o; endproperty
	a_precharge_all_cmd: assert property (p_precharge_all_cmd) else $error("precharge after bus given up");
	property p_ctrl; $fell(bus_ack_n_o) |-> $past(ctrl_high_o); endproperty
	a_ctrl: assert property (p_ctrl) else $error("ack low before controls high");
	property p_end; $rose(ext_bus_request_n_i) && !bus_ack_n_o |-> ##[1:12] bus_ack_n_o; endproperty
	a_end: assert property (p_end) else $error("release not ended");
	property p_rcl_idle; bus_ack_n_o && $past(bus_ack_n_o) |-> bus_reclaim_request_n_o; endproperty
	a_rcl_idle: assert property (p_rcl_idle) else $error("reclaim low outside release");
	property p_rcl; $rose(bus_ack_n_o) |-> ##[0:1] bus_reclaim_request_n_o; endproperty
	a_rcl: assert property (p_rcl) else $error("reclaim not withdrawn");
	property p_one; $onehot0({dma_gnt_o, tc_gnt_o, cpu_gnt_o}); endproperty
	a_one: assert property (p_one) else $error("several grants");
	property p_defer; !bus_ack_n_o |-> !ext_go_o && !refresh_go_o; endproperty
	a_defer: assert property (p_defer) else $error("external cycle while released");
	property p_reen; ext_go_o || refresh_go_o |-> ext_out_en_o; endproperty
	a_reen: assert property (p_reen) else $error("cycle with outputs floating");
	property p_ebuf; $rose(ext_wr_run_i) |-> s_alone(int_go_o); endproperty
	a_ebuf: assert property (p_ebuf) else $error("internal access too early");
	property p_pbuf; $rose(per_wr_run_i) |-> s_alone(mem_go_o); endproperty
	a_pbuf: assert property (p_pbuf) else $error("memory access too early");
endmodule
bind bar_arbiter bar_arbiter_asserts u_chk (.clock_i(clock_i), .reset_i(reset_i),
	.ext_bus_request_n_i(ext_bus_request_n_i), .bus_ack_n_o(bus_ack_n_o),
	.bus_reclaim_request_n_o(bus_reclaim_request_n_o), .ctrl_high_o(ctrl_high_o),
	.ext_out_en_o(ext_out_en_o), .dma_ack_out_n_force_o(dma_ack_out_n_force_o),
	.precharge_all_cmd_o(precharge_all_cmd_o), .ext_go_o(ext_go_o), .refresh_go_o(refresh_go_o),
	.dma_gnt_o(dma_gnt_o), .tc_gnt_o(tc_gnt_o), .cpu_gnt_o(cpu_gnt_o), .ext_wr_run_i(ext_wr_run_i),
	.per_wr_run_i(per_wr_run_i), .int_go_o(int_go_o), .mem_go_o(mem_go_o));

// ==== test/bar_arbiter_tb.sv ====
// self-checking bench for the bus arbiter
// assumes the arbiter, its checker and the external master model
`timescale 1ns/1ns
`include "bar_map.vh"
module bar_arbiter_tb;
	reg clock_i, reset_i, bce, rw, rr, go, dma, dx, tc, cpu, lock, pa, pw, ew, ia, pr, ma, rf, bz;
	reg [3:0] ra;
	reg [7:0] wd;
	reg [1:0] pc;
	reg [2:0] len;
	wire [7:0] rdat;
	wire dg, tg, cg, rg, eg, precharge_all_cmd, ack, rcl, ch, oe, df, pd, pb, ig, mg, rq, done;
	integer err_count, n_compared, cyc, i, k;
	bar_arbiter DUT (.clock_i(clock_i), .reset_i(reset_i), .bus_clk_en_i(bce), .per_clk_en_i(bce),
		.reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(rw), .reg_rd_i(rr), .reg_rdata_o(rdat),
		.dma_req_i(dma), .dma_ext_i(dx), .tc_req_i(tc), .tc_ext_i(dx), .cpu_req_i(cpu), .cpu_ext_i(dx),
		.cpu_cycle_end_i(1'b1), .cpu_sleep_i(1'b0), .cpu_locked_i(lock), .cpu_blk_yield_i(1'b0),
		.dma_gnt_o(dg), .tc_gnt_o(tg), .cpu_gnt_o(cg), .refresh_req_i(rf), .ext_cycle_busy_i(bz),
		.refresh_go_o(rg), .ext_go_o(eg), .precharge_all_cmd_o(precharge_all_cmd), .ext_bus_request_n_i(rq),
		.bus_ack_n_o(ack), .bus_reclaim_request_n_o(rcl), .ctrl_high_o(ch), .ext_out_en_o(oe),
		.dma_ack_out_n_force_o(df), .per_acc_i(pa), .per_wr_i(pw), .per_class_i(pc), .per_ratio_i(3'h1),
		.per_done_o(pd), .per_buffered_o(pb), .ext_wr_run_i(ew), .int_acc_i(ia), .per_wr_run_i(pr),
		.mem_acc_i(ma), .int_go_o(ig), .mem_go_o(mg));
	bar_ext_master u_mst (.clock_i(clock_i), .reset_i(reset_i), .go_i(go), .hold_i(8'h06),
		.done_o(done), .bus_ack_n_i(ack), .request_n_o(rq));
	////////////////////////////////////////////////////////////////
	// clock, bus clock enable and hang guard
	always #5 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		bce <= ~bce;
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			give_verdict;
		end
	end
	////////////////////////////////////////////////////////////////
	task chk(input string nm, input [7:0] e, input [7:0] g);
		n_compared = n_compared + 1;
		if (g !== e) begin
			err_count = err_count + 1;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		@(posedge clock_i);
		ra <= a;
		wd <= d;
		rw <= 1'b1;
		@(posedge clock_i);
		rw <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task rd(input [3:0] a, input [7:0] e, input string nm);
		@(posedge clock_i);
		ra <= a;
		rr <= 1'b1;
		@(posedge clock_i);
		rr <= 1'b0;
		#1 chk(nm, e, rdat);
	endtask
	task t_regs;
		rd(`BAR_OFS_CTRL, `BAR_CTL_RESET, "ctrl reset");
		rd(`BAR_OFS_STAT, 8'h1a, "status idle");
		wr(`BAR_OFS_CTRL, 8'h3f);
		rd(`BAR_OFS_CTRL, 8'h3f, "ctrl back");
		rd(4'h7, 8'h00, "unmapped");
		$display("t_regs done");
	endtask
	// release with a reclaim wish raised while the bus is away
	task t_release;
		wr(`BAR_OFS_CTRL, 8'h07);
		k = 0;
		go <= 1'b1;
		// a running external cycle must hold off the hand-over
		bz <= 1'b1;
		for (i = 0; i < 20; i = i + 1) begin
			@(posedge clock_i);
			if (precharge_all_cmd === 1'b1) k = 1;
		end
		chk("controls wait busy", 0, ch);
		chk("ack wait busy", 1, ack);
		bz <= 1'b0;
		for (i = 0; i < 40 && ack !== 1'b0; i = i + 1) begin
			@(posedge clock_i);
			if (precharge_all_cmd === 1'b1) k = 1;
		end
		chk("ack low", 0, ack);
		chk("controls high", 1, ch);
		chk("precharge seen", 1, k);
		chk("outputs float", 0, oe);
		chk("dma ack held", 1, df);
		dma <= 1'b1;
		dx <= 1'b1;
		for (i = 0; i < 20 && rcl !== 1'b0; i = i + 1)
			@(posedge clock_i);
		chk("reclaim low", 0, rcl);
		chk("ext deferred", 0, eg);
		for (i = 0; i < 40 && done !== 1'b1; i = i + 1)
			@(posedge clock_i);
		go <= 1'b0;
		for (i = 0; i < 20 && ack !== 1'b1; i = i + 1)
			@(posedge clock_i);
		chk("ack high", 1, ack);
		chk("reclaim high", 1, rcl);
		for (i = 0; i < 20 && eg !== 1'b1; i = i + 1)
			@(posedge clock_i);
		chk("outputs back", 1, oe);
		dma <= 1'b0;
		dx <= 1'b0;
		$display("t_release done");
	endtask
	// release refused without the input buffer bit
	task t_refuse;
		wr(`BAR_OFS_CTRL, 8'h05);
		go <= 1'b1;
		repeat (30) @(posedge clock_i);
		chk("no release", 1, ack);
		go <= 1'b0;
		$display("t_refuse done");
	endtask
	// refresh outranks an external access by a granted master
	task t_refresh;
		dma <= 1'b1;
		dx <= 1'b1;
		rf <= 1'b1;
		repeat (4) @(posedge clock_i);
		chk("refresh first", 8'h02, {rg, eg});
		rf <= 1'b0;
		repeat (3) @(posedge clock_i);
		chk("access after refresh", 8'h01, {rg, eg});
		dma <= 1'b0;
		dx <= 1'b0;
		$display("t_refresh done");
	endtask
	// cpu slots interleave with a continuing dma stream
	task t_alt;
		wr(`BAR_OFS_CTRL, 8'h20);
		dma <= 1'b1;
		cpu <= 1'b1;
		for (i = 0; i < 20 && dg !== 1'b1; i = i + 1)
			@(posedge clock_i);
		@(posedge clock_i);
		chk("cpu slot", 8'h01, {dg, tg, cg});
		@(posedge clock_i);
		chk("dma slot", 8'h04, {dg, tg, cg});
		dma <= 1'b0;
		cpu <= 1'b0;
		$display("t_alt done");
	endtask
	task t_arb;
		dma <= 1'b1;
		tc <= 1'b1;
		cpu <= 1'b1;
		for (i = 0; i < 20 && dg !== 1'b1; i = i + 1)
			@(posedge clock_i);
		chk("grants dma first", 8'h04, {dg, tg, cg});
		dma <= 1'b0;
		for (i = 0; i < 20 && tg !== 1'b1; i = i + 1)
			@(posedge clock_i);
		chk("grants tc next", 8'h02, {dg, tg, cg});
		tc <= 1'b0;
		for (i = 0; i < 20 && cg !== 1'b1; i = i + 1)
			@(posedge clock_i);
		lock <= 1'b1;
		dma <= 1'b1;
		repeat (10) @(posedge clock_i);
		chk("cpu keeps bus", 8'h01, {dg, tg, cg});
		lock <= 1'b0;
		for (i = 0; i < 20 && dg !== 1'b1; i = i + 1)
			@(posedge clock_i);
		chk("cpu yields", 1, dg);
		dma <= 1'b0;
		cpu <= 1'b0;
		$display("t_arb done");
	endtask
	// buffered writes let the other side go, unbuffered ones hold it
	task t_wbuf;
		for (k = 0; k < 2; k = k + 1) begin
			wr(`BAR_OFS_CTRL, k ? 8'h00 : 8'h18);
			ew <= 1'b1;
			ia <= 1'b1;
			pr <= 1'b1;
			ma <= 1'b1;
			repeat (4) @(posedge clock_i);
			chk("internal go", !k, ig);
			chk("memory go", !k, mg);
			ew <= 1'b0;
			ia <= 1'b0;
			pr <= 1'b0;
			ma <= 1'b0;
		end
		$display("t_wbuf done");
	endtask
	task t_per;
		wr(`BAR_OFS_CTRL, 8'h10);
		// the last pass is a system register read
		for (k = 0; k < 5; k = k + 1) begin
			len = (k == 4) ? `BAR_SYS_RD_CYC : (k == 3) ? `BAR_OTH_CYC : `BAR_PM_CYC;
			@(posedge clock_i);
			pc <= (k == 4) ? 2'h0 : k;
			pw <= (k != 4);
			pa <= 1'b1;
			@(posedge clock_i);
			pa <= 1'b0;
			#1 chk("buffered", k == 2 || k == 3, pb);
			for (i = 1; i < 20 && pd !== 1'b1; i = i + 1)
				@(posedge clock_i);
			chk("access length", 1, i >= len && i <= 2 * len + 4);
			if (k == 0 || k == 4)
				chk("system length", len + 2, i);
		end
		pw <= 1'b0;
		$display("t_per done");
	endtask
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{clock_i, bce, rw, rr, go, dma, dx, tc, cpu, lock, pa, pw, ew, ia, pr, ma, rf, bz} = 0;
		{ra, wd, pc} = 0;
		err_count = 0;
		n_compared = 0;
		cyc = 0;
		reset_i = 1'b1;
		repeat (10) @(posedge clock_i);
		reset_i <= 1'b0;
		t_regs;
		t_release;
		t_refuse;
		t_refresh;
		t_arb;
		t_alt;
		t_wbuf;
		t_per;
		give_verdict;
	end
endmodule

// ==== test/bar_ext_master.sv ====
// model of the external bus master asking for the shared bus
// assumes the bench raises go and lowers it once done is seen
`timescale 1ns/1ns
module bar_ext_master (
	// clock and reset
	input wire clock_i,
	input wire reset_i,
	// bench control
	input wire go_i,
	input wire [7:0] hold_i,
	output wire done_o,
	// bus pins
	input wire bus_ack_n_i,
	output reg request_n_o
);
	reg [7:0] cnt_r; // cycles used while the bus is ours
	assign done_o = (cnt_r == hold_i);
	// request stays low for the whole use, then is withdrawn
	always @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			request_n_o <= 1'b1;
			cnt_r <= 8'h00;
		end else if (!go_i) begin
			request_n_o <= 1'b1;
			cnt_r <= 8'h00;
		end else if (cnt_r == hold_i) begin
			request_n_o <= 1'b1;
		end else begin
			request_n_o <= 1'b0;
			if (!bus_ack_n_i)
				cnt_r <= cnt_r + 8'h01;
		end
	end
endmodule

// ==== verilog/bar_arbiter.v ====
// bus arbitration, external bus release handshake and write buffer pacing
// assumes single clock; the bus clock is an enable pulse; pins are tristated outside
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "bar_map.vh"

module bar_arbiter #(
	parameter DIV_W = 3 // width of peripheral clock ratio field
) (
	// clock and reset
	input wire clock_i,
	input wire reset_i,
	input wire bus_clk_en_i, // one-cycle pulse per bus clock edge
	input wire per_clk_en_i, // one-cycle pulse per peripheral clock edge
	// register port
	input wire [3:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	// internal requesters
	input wire dma_req_i,
	input wire dma_ext_i, // dma wants external space
	input wire tc_req_i,
	input wire tc_ext_i,
	input wire cpu_req_i,
	input wire cpu_ext_i,
	input wire cpu_cycle_end_i, // cpu bus cycle boundary
	input wire cpu_sleep_i,
	input wire cpu_locked_i, // split, stack, transfer or rmw in progress
	input wire cpu_blk_yield_i, // block transfer at write or following read
	output wire dma_gnt_o,
	output wire tc_gnt_o,
	output wire cpu_gnt_o,
	// external arbiter side
	input wire refresh_req_i,
	input wire ext_cycle_busy_i, // external access cycle in progress
	output reg refresh_go_o,
	output reg ext_go_o,
	output reg precharge_all_cmd_o,
	// external bus release pins
	input wire ext_bus_request_n_i,
	output reg bus_ack_n_o,
	output reg bus_reclaim_request_n_o,
	output reg ctrl_high_o, // bus control outputs forced inactive
	output reg ext_out_en_o, // enable for address, data, strobes, dram
	output wire dma_ack_out_n_force_o, // dma acks held high while released
	// peripheral register access
	input wire per_acc_i,
	input wire per_wr_i,
	input wire [1:0] per_class_i,
	input wire [DIV_W-1:0] per_ratio_i, // n of 1:n
	output reg per_done_o,
	output wire per_buffered_o,
	// write buffers
	input wire ext_wr_run_i, // external write or single address dma
	input wire int_acc_i,
	input wire per_wr_run_i,
	input wire mem_acc_i,
	output wire int_go_o,
	output wire mem_go_o
);

////////////////////////////////////////////////////////////////////////
// registers and pin sampling

reg [7:0] ctrl_r; // software control
reg req_s1_r; // request pin synchroniser stage one
reg req_s2_r; // synchronised request
reg req_smp_r; // request level sampled on bus clock
wire release_ok; // release allowed by enables
wire rel_enb;
wire reclaim_enb;
wire ext_wbuf;
wire per_wbuf;
wire cpu_alt;

assign release_ok = ctrl_r[`BAR_CTL_RELEASE_EN] & ctrl_r[`BAR_CTL_ICR]; // R23
assign rel_enb = release_ok;
assign reclaim_enb = ctrl_r[`BAR_CTL_RECLAIM_EN];
assign ext_wbuf = ctrl_r[`BAR_CTL_EXT_WBUF];
assign per_wbuf = ctrl_r[`BAR_CTL_PER_WBUF];
assign cpu_alt = ctrl_r[`BAR_CTL_CPU_ALT];

// pin through two flops, then sampled on bus clock edges
always @(posedge clock_i or posedge reset_i) begin
	if (reset_i) begin
		req_s1_r <= 1'b1;
		req_s2_r <= 1'b1;
		req_smp_r <= 1'b1;
	end else begin
		req_s1_r <= ext_bus_request_n_i;
		req_s2_r <= req_s1_r;
		if (bus_clk_en_i)
			req_smp_r <= req_s2_r; // R2
	end
end

////////////////////////////////////////////////////////////////////////
// release state machine

localparam ST_IDLE = 5'h01; // bus owned by device
localparam ST_PRECHARGE_ALL_CMD = 5'h02; // precharge-all issued
localparam ST_WAIT = 5'h04; // waiting for cycle end and minimum delay
localparam ST_REL = 5'h08; // bus released
localparam ST_BACK = 5'h10; // acknowledge back high, outputs re-enabled on leaving this state

reg [4:0] st_r;
reg [4:0] st_nxt;
reg [2:0] dly_r; // bus clocks since precharge-all issued, saturating at 7
wire req_low;

assign req_low = ~req_smp_r & rel_enb;

// next state, advanced on bus clock pulses
always @* begin
	st_nxt = st_r;
	case (st_r)
		ST_IDLE: begin
			if (req_low)
				st_nxt = ST_PRECHARGE_ALL_CMD;
		end
		ST_PRECHARGE_ALL_CMD: begin
			st_nxt = ST_WAIT; // R3
		end
		ST_WAIT: begin
			// controls go high only after cycle end, at least two clocks
			if (!ext_cycle_busy_i && dly_r >= `BAR_REL_MIN_CYC)
				st_nxt = ST_REL; // R4
		end
		ST_REL: begin
			if (req_smp_r)
				st_nxt = ST_BACK; // R6
		end
		ST_BACK: begin
			st_nxt = ST_IDLE; // R25
		end
		default: begin
			st_nxt = ST_IDLE;
		end
	endcase
end

// state, delay count and pin outputs
always @(posedge clock_i or posedge reset_i) begin
	if (reset_i) begin
		st_r <= ST_IDLE;
		dly_r <= 3'h0;
		bus_ack_n_o <= 1'b1;
		ctrl_high_o <= 1'b0;
		ext_out_en_o <= 1'b1;
		precharge_all_cmd_o <= 1'b0;
	end else begin
		precharge_all_cmd_o <= 1'b0;
		if (bus_clk_en_i) begin
			st_r <= st_nxt;
			if (st_r == ST_IDLE)
				dly_r <= 3'h0;
			else if (dly_r != 3'h7)
				dly_r <= dly_r + 3'h1;
			if (st_r == ST_IDLE && st_nxt == ST_PRECHARGE_ALL_CMD)
				precharge_all_cmd_o <= 1'b1; // R3
			if (st_nxt == ST_REL && st_r == ST_WAIT)
				ctrl_high_o <= 1'b1; // R4
			if (st_r == ST_REL && st_nxt == ST_REL && !ctrl_high_o == 1'b0) begin
				bus_ack_n_o <= 1'b0; // R5
				ext_out_en_o <= 1'b0; // R1
			end
			if (st_nxt == ST_BACK)
				bus_ack_n_o <= 1'b1; // R6
			if (st_r == ST_BACK) begin
				ext_out_en_o <= 1'b1; // R25
				ctrl_high_o <= 1'b0;
			end
		end
	end
end

assign dma_ack_out_n_force_o = ~ext_out_en_o; // R1

////////////////////////////////////////////////////////////////////////
// external arbiter

wire int_ext_need; // granted internal master wants external space
wire released; // release in progress, from precharge-all until back in idle

assign released = (st_r != ST_IDLE);

// refresh first, then release, then external access
always @(posedge clock_i or posedge reset_i) begin
	if (reset_i) begin
		refresh_go_o <= 1'b0;
		ext_go_o <= 1'b0;
	end else begin
		refresh_go_o <= refresh_req_i & ~released; // R16 R24
		ext_go_o <= int_ext_need & ~refresh_req_i & ~released & ~req_low; // R16 R24
	end
end

// reclaim request while released; rises with acknowledge
// the end of release is decoded from the state so both pins rise on one edge
always @(posedge clock_i or posedge reset_i) begin
	if (reset_i)
		bus_reclaim_request_n_o <= 1'b1;
	else if (bus_clk_en_i && st_nxt == ST_BACK)
		bus_reclaim_request_n_o <= 1'b1; // R8
	else if (bus_ack_n_o == 1'b0 && reclaim_enb && (int_ext_need | refresh_req_i))
		bus_reclaim_request_n_o <= 1'b0; // R7
	else if (bus_ack_n_o == 1'b1)
		bus_reclaim_request_n_o <= 1'b1; // R8
end

////////////////////////////////////////////////////////////////////////
// internal arbiter

localparam G_NONE = 3'h0;
localparam G_DMA = 3'h1;
localparam G_TC = 3'h2;
localparam G_CPU = 3'h4;

reg [2:0] gnt_r;
reg [2:0] gnt_nxt;
reg last_cpu_r; // cpu had the previous slot in alternate mode
wire cpu_can_yield;
wire hi_req;

assign hi_req = dma_req_i | tc_req_i;
// cpu hands over at a cycle end or in sleep, unless locked
assign cpu_can_yield = ((cpu_cycle_end_i | cpu_sleep_i) & ~cpu_locked_i) | cpu_blk_yield_i; // R20 R21 R22

// grant selection; internal accesses are independent of release
always @* begin
	gnt_nxt = gnt_r;
	case (gnt_r)
		G_NONE: begin
			if (dma_req_i)
				gnt_nxt = G_DMA; // R15
			else if (tc_req_i)
				gnt_nxt = G_TC; // R15
			else if (cpu_req_i)
				gnt_nxt = G_CPU; // R15
		end
		G_DMA: begin
			if (!dma_req_i)
				gnt_nxt = G_NONE; // R17
			else if (cpu_alt && cpu_req_i && !last_cpu_r)
				gnt_nxt = G_CPU; // R18
		end
		G_TC: begin
			if (dma_req_i)
				gnt_nxt = G_DMA; // R15
			else if (!tc_req_i)
				gnt_nxt = G_NONE; // R17
			else if (cpu_alt && cpu_req_i && !last_cpu_r)
				gnt_nxt = G_CPU; // R18
		end
		G_CPU: begin
			if (hi_req && cpu_can_yield)
				gnt_nxt = dma_req_i ? G_DMA : G_TC; // R18 R20
			else if (!cpu_req_i && !cpu_locked_i)
				gnt_nxt = G_NONE; // R17
		end
		default: begin
			gnt_nxt = G_NONE;
		end
	endcase
end

always @(posedge clock_i or posedge reset_i) begin
	if (reset_i) begin
		gnt_r <= G_NONE;
		last_cpu_r <= 1'b0;
	end else begin
		gnt_r <= gnt_nxt; // R19
		if (gnt_nxt != gnt_r)
			last_cpu_r <= (gnt_nxt == G_CPU);
	end
end

assign dma_gnt_o = gnt_r[0];
assign tc_gnt_o = gnt_r[1];
assign cpu_gnt_o = gnt_r[2];
assign int_ext_need = (gnt_r[0] & dma_ext_i) | (gnt_r[1] & tc_ext_i) | (gnt_r[2] & cpu_ext_i);

////////////////////////////////////////////////////////////////////////
// peripheral register access timing

reg [2:0] per_cnt_r; // access cycles left
reg [DIV_W-1:0] sync_r; // sync cycles left, clock alignment
reg per_busy_r;
reg [2:0] acc_len;

// length by class; system and watchdog groups bypass the buffer
always @* begin
	case (per_class_i)
		`BAR_CLS_SYS: acc_len = per_wr_i ? `BAR_SYS_WR_CYC : `BAR_SYS_RD_CYC; // R10
		`BAR_CLS_PFW: acc_len = per_wr_i ? `BAR_PFW_WR_CYC : `BAR_PFW_RD_CYC; // R11
		`BAR_CLS_PM: acc_len = `BAR_PM_CYC; // R12
		default: acc_len = `BAR_OTH_CYC;
	endcase
end

assign per_buffered_o = per_wbuf & per_wr_i & per_class_i[1]; // R10 R11 R12

// system class counts system clocks; others wait for the peripheral edge
always @(posedge clock_i or posedge reset_i) begin
	if (reset_i) begin
		per_cnt_r <= 3'h0;
		sync_r <= {DIV_W{1'b0}};
		per_busy_r <= 1'b0;
		per_done_o <= 1'b0;
	end else begin
		per_done_o <= 1'b0;
		if (per_acc_i && !per_busy_r) begin
			per_busy_r <= 1'b1;
			per_cnt_r <= acc_len;
			// up to n-1 cycles until the next peripheral clock edge
			sync_r <= (per_class_i == `BAR_CLS_SYS) ? {DIV_W{1'b0}} : per_ratio_i - 1'b1; // R9
		end else if (per_busy_r) begin
			if (sync_r != {DIV_W{1'b0}} && !per_clk_en_i)
				sync_r <= sync_r - 1'b1; // R9
			else if (sync_r != {DIV_W{1'b0}})
				sync_r <= {DIV_W{1'b0}};
			else if (per_class_i == `BAR_CLS_SYS || per_clk_en_i) begin
				if (per_cnt_r == 3'h1) begin
					per_busy_r <= 1'b0;
					per_done_o <= 1'b1;
				end
				per_cnt_r <= per_cnt_r - 3'h1;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////
// write data buffer pacing

reg [1:0] ext_run_r; // cycles the external write has run alone
reg [1:0] per_run_r;

always @(posedge clock_i or posedge reset_i) begin
	if (reset_i) begin
		ext_run_r <= 2'h0;
		per_run_r <= 2'h0;
	end else begin
		if (!ext_wr_run_i)
			ext_run_r <= 2'h0;
		else if (ext_run_r != `BAR_WBUF_ALONE_CYC)
			ext_run_r <= ext_run_r + 2'h1;
		if (!per_wr_run_i)
			per_run_r <= 2'h0;
		else if (per_run_r != `BAR_WBUF_ALONE_CYC)
			per_run_r <= per_run_r + 2'h1;
	end
end

// internal access waits for the write unless the buffer is enabled and two cycles have run alone
assign int_go_o = int_acc_i & (~ext_wr_run_i | (ext_wbuf & ext_run_r == `BAR_WBUF_ALONE_CYC)); // R13
assign mem_go_o = mem_acc_i & (~per_wr_run_i | (per_wbuf & per_run_r == `BAR_WBUF_ALONE_CYC)); // R14

////////////////////////////////////////////////////////////////////////
// register port

always @(posedge clock_i or posedge reset_i) begin
	if (reset_i) begin
		ctrl_r <= `BAR_CTL_RESET;
		reg_rdata_o <= 8'h00;
	end else begin
		reg_rdata_o <= 8'h00;
		if (reg_wr_i && reg_addr_i == `BAR_OFS_CTRL)
			ctrl_r <= reg_wdata_i;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`BAR_OFS_CTRL: reg_rdata_o <= ctrl_r;
				`BAR_OFS_STAT: reg_rdata_o <= {gnt_r, bus_reclaim_request_n_o, bus_ack_n_o, released, req_smp_r, per_busy_r};
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end
end

endmodule

// ==== verilog/bar_map.vh ====
// constant definitions for the bus arbitration and release block
// assumes inclusion by the design module and the bench that use them
// Notes on behaviour
// [R1] released bus: outputs float, dma acks high
// [R2] sample request low on bus clock edge
// [R3] issue precharge-all before giving up bus
// [R4] controls high at cycle end, two+ cycles
// [R5] then drive acknowledge low to release
// [R6] request high sampled: ack high next cycle
// [R7] reclaim request low when enabled and needed
// [R8] reclaim request high at acknowledge rise
// [R9] insert 0..n-1 sync cycles, peripheral access
// [R10] system regs: read two, write three, unbuffered
// [R11] port function, watchdog: two/three, unbuffered
// [R12] port m, usb, serial: three, buffered
// [R13] external write buffer: two alone, then parallel
// [R14] peripheral write buffer: two alone, then parallel
// [R15] internal rank: dma, transfer controller, cpu
// [R16] external rank: refresh, release, access
// [R17] grant only highest; hold until withdrawn
// [R18] alternate cpu with streams when selected
// [R19] internal access, release, refresh run concurrently
// [R20] cpu yields at cycle end or sleep clock
// [R21] cpu never yields inside locked sequences
// [R22] block transfer may yield at write/read
// [R23] release only with enable and input buffer
// [R24] released: external cycle waits for withdrawal
// [R25] re-enable outputs before deferred cycles
`ifndef BAR_MAP_VH
`define BAR_MAP_VH
// register offsets on the plain port
`define BAR_OFS_CTRL 4'h0
`define BAR_OFS_STAT 4'h1
// control field positions
`define BAR_CTL_RELEASE_EN 0
`define BAR_CTL_ICR 1
`define BAR_CTL_RECLAIM_EN 2
`define BAR_CTL_EXT_WBUF 3
`define BAR_CTL_PER_WBUF 4
`define BAR_CTL_CPU_ALT 5
`define BAR_CTL_RESET 8'h00
// access cycle counts
`define BAR_SYS_RD_CYC 3'h2
`define BAR_SYS_WR_CYC 3'h3
`define BAR_PFW_RD_CYC 3'h2
`define BAR_PFW_WR_CYC 3'h3
`define BAR_PM_CYC 3'h3
`define BAR_OTH_CYC 3'h2
// minimum bus clocks counted from precharge-all before controls go high
`define BAR_REL_MIN_CYC 3'h2
// cycles a buffered write runs alone
`define BAR_WBUF_ALONE_CYC 2'h2
// peripheral register classes
`define BAR_CLS_SYS 2'h0
`define BAR_CLS_PFW 2'h1
`define BAR_CLS_PM 2'h2
`define BAR_CLS_OTH 2'h3
`endif
